// ===== rtl/pps_pkg.sv
`default_nettype none
package pps_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] PPS_OFS_PULLUP = 4'h0;
   localparam logic [3:0] PPS_OFS_FUNC = 4'h4;
   localparam logic [3:0] PPS_OFS_DIR = 4'h8;
   localparam logic [3:0] PPS_OFS_DATA = 4'hC;
   localparam logic [7:0] PPS_PULLUP_RST = 8'h00;
   localparam logic [7:0] PPS_FUNC_RST = 8'h00;
   localparam logic [7:0] PPS_DIR_RST = 8'h00;
   localparam logic [7:0] PPS_DATA_RST = 8'h00;
   // ----------------------------------------
   // Function select bit positions
   // ----------------------------------------
   localparam int PPS_BIT_CLKOUT = 0;
   localparam int PPS_BIT_TFL = 1;
   localparam int PPS_BIT_TFH = 2;
   localparam int PPS_BIT_RSV = 3;
   localparam int PPS_BIT_PWM = 4;
   localparam int PPS_BIT_INT1 = 5;
   localparam int PPS_BIT_INT2 = 6;
   localparam int PPS_BIT_INT3 = 7;
   // Writable bits on the full and reduced variants
   localparam logic [7:0] PPS_MASK_FULL = 8'hFF;
   localparam logic [7:0] PPS_MASK_REDUCED = 8'hA7;
   localparam logic [7:0] PPS_FUNC_MASK_FULL = 8'hF7;
   localparam logic [7:0] PPS_FUNC_MASK_REDUCED = 8'hA7;
   localparam logic [31:0] PPS_UNMAPPED_DATA = 32'h0000_0000;
endpackage : pps_pkg
`default_nettype wire

// ===== rtl/pps_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none
module pps_pin_cell (
   input wire logic func_sel,     // Peripheral function selected
   input wire logic periph_is_out, // Peripheral drives the pin
   input wire logic periph_out,   // Peripheral output value
   input wire logic dir_out,      // General I/O direction, 1 = output
   input wire logic data_out,     // General I/O output data
   input wire logic pullup_bit,   // Pull-up control bit
   input wire logic pin_in,       // Pin level
   output logic pin_out,          // Pin output value
   output logic pin_oe,           // Pin output enable
   output logic pullup_en,        // MOS pull-up on
   output logic gpio_in,          // Pin level to general I/O read path
   output logic periph_in         // Pin level to peripheral input
);
   logic drives;
   assign drives = func_sel ? periph_is_out : dir_out;
   assign pin_oe = drives;
   assign pin_out = func_sel ? periph_out : data_out;
   // Pull-up only on a pin that is not driving
   assign pullup_en = pullup_bit & ~drives;
   assign gpio_in = pin_in;
   // Peripheral inputs see the pin only when selected; idle level high
   assign periph_in = func_sel ? pin_in : 1'b1;
endmodule : pps_pin_cell
`default_nettype wire

// ===== rtl/pps_port1.sv
// Overview of operation
// - Input pin with pull-up bit set: pull-up on
// - Pull-up bit clear keeps pull-up off
// - Reset clears pull-up control register
// - Function register 8-bit RW except bit 3 (also bits 6 and 4 when REDUCED), which reads zero; reset to zero
// - Bit 7 selects interrupt 3 / timer F event
// - Bit 6 selects interrupt 2 / timer C event
// - Bit 5 selects interrupt 1 / timer B event
// - Bit 4 selects PWM output on pin 4
// - Bit 2 selects timer F high compare
// - Bit 1 selects timer F low compare
// - Bit 0 selects clock output on pin 0
// - Shared interrupt pins pass both edge polarities
// - Direction and data apply only in general I/O
`timescale 1ns/1ns
`default_nettype none
module pps_port1
   import pps_pkg::*;
#(
   parameter bit REDUCED = 1'b0,
   parameter int NPINS = 8
) (
   input wire logic clk,                     // System clock
   input wire logic nrst,                    // Async reset, active low
   input wire logic [3:0] avs_address,       // Byte address
   input wire logic avs_read,                // Read strobe
   input wire logic avs_write,               // Write strobe
   input wire logic [3:0] avs_byteenable,    // Byte enables
   input wire logic [31:0] avs_writedata,    // Write data
   output logic [31:0] avs_readdata,         // Read data
   output logic avs_waitrequest,             // Wait request
   input wire logic [NPINS-1:0] pin_in,      // Pin levels
   output logic [NPINS-1:0] pin_out,         // Pin output values
   output logic [NPINS-1:0] pin_oe,          // Pin output enables
   output logic [NPINS-1:0] pullup_en,       // MOS pull-up enables
   input wire logic pwm_out,                 // PWM generator output
   input wire logic timer_f_high_compare_out, // Timer F high compare
   input wire logic timer_f_low_compare_out, // Timer F low compare
   input wire logic clock_out,               // Clock output source
   output logic ext_int3_in,                 // Interrupt 3 input
   output logic ext_int2_in,                 // Interrupt 2 input
   output logic ext_int1_in,                 // Interrupt 1 input
   output logic timer_f_event_input,         // Timer F event
   output logic timer_c_event_input,         // Timer C event
   output logic timer_b_event_input          // Timer B event
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] pullup_control_reg_ff;
   logic [7:0] pin_function_reg_ff;
   logic [7:0] direction_reg_ff;
   logic [7:0] output_data_reg_ff;
   logic [31:0] readdata_ff;
   logic ack_ff;
   logic [7:0] wmask;
   logic [7:0] fmask;
   logic [7:0] nxt_wbyte;
   logic [7:0] gpio_in;
   logic [7:0] periph_in;
   logic [7:0] periph_is_out;
   logic [7:0] periph_out;
   logic [7:0] rd_byte;
   logic wr_go;
   logic rd_go;

   // Reserved bits are held at zero in hardware, so a stray write is harmless
   assign wmask = REDUCED ? PPS_MASK_REDUCED : PPS_MASK_FULL;
   assign fmask = REDUCED ? PPS_FUNC_MASK_REDUCED : PPS_FUNC_MASK_FULL;
   assign nxt_wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

   // ----------------------------------------
   // Bus slave: one wait state per access
   // ----------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign wr_go = avs_write & ~ack_ff;
   assign rd_go = avs_read & ~ack_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read | avs_write) & ~ack_ff;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pullup_control_reg_ff <= PPS_PULLUP_RST;
      end else if (wr_go && avs_byteenable[0] && avs_address == PPS_OFS_PULLUP) begin
         pullup_control_reg_ff <= nxt_wbyte & wmask;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_function_reg_ff <= PPS_FUNC_RST;
      end else if (wr_go && avs_byteenable[0] && avs_address == PPS_OFS_FUNC) begin
         pin_function_reg_ff <= nxt_wbyte & fmask;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         direction_reg_ff <= PPS_DIR_RST;
      end else if (wr_go && avs_byteenable[0] && avs_address == PPS_OFS_DIR) begin
         direction_reg_ff <= nxt_wbyte & wmask;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         output_data_reg_ff <= PPS_DATA_RST;
      end else if (wr_go && avs_byteenable[0] && avs_address == PPS_OFS_DATA) begin
         output_data_reg_ff <= nxt_wbyte & wmask;
      end
   end

   // Data read: output pins return latch, input pins return level
   always_comb begin
      rd_byte = 8'h00;
      case (avs_address)
         PPS_OFS_PULLUP: rd_byte = pullup_control_reg_ff;
         PPS_OFS_FUNC: rd_byte = pin_function_reg_ff;
         PPS_OFS_DIR: rd_byte = direction_reg_ff;
         PPS_OFS_DATA: rd_byte = ((direction_reg_ff & output_data_reg_ff)
                                  | (~direction_reg_ff & gpio_in)) & wmask;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         readdata_ff <= PPS_UNMAPPED_DATA;
      end else if (rd_go) begin
         readdata_ff <= {24'h000000, rd_byte};
      end
   end
   assign avs_readdata = readdata_ff;

   // ----------------------------------------
   // Peripheral routing
   // ----------------------------------------
   always_comb begin
      periph_is_out = 8'h00;
      periph_out = 8'h00;
      periph_is_out[PPS_BIT_PWM] = 1'b1;
      periph_out[PPS_BIT_PWM] = pwm_out;
      periph_is_out[PPS_BIT_TFH] = 1'b1;
      periph_out[PPS_BIT_TFH] = timer_f_high_compare_out;
      periph_is_out[PPS_BIT_TFL] = 1'b1;
      periph_out[PPS_BIT_TFL] = timer_f_low_compare_out;
      periph_is_out[PPS_BIT_CLKOUT] = 1'b1;
      periph_out[PPS_BIT_CLKOUT] = clock_out;
   end

   // Edge polarity is chosen in the interrupt and timer blocks
   assign ext_int3_in = periph_in[PPS_BIT_INT3];
   assign timer_f_event_input = periph_in[PPS_BIT_INT3];
   assign ext_int2_in = periph_in[PPS_BIT_INT2];
   assign timer_c_event_input = periph_in[PPS_BIT_INT2];
   assign ext_int1_in = periph_in[PPS_BIT_INT1];
   assign timer_b_event_input = periph_in[PPS_BIT_INT1];

   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         pps_pin_cell u_cell (
            .func_sel(pin_function_reg_ff[gi]),
            .periph_is_out(periph_is_out[gi]),
            .periph_out(periph_out[gi]),
            .dir_out(direction_reg_ff[gi]),
            .data_out(output_data_reg_ff[gi]),
            .pullup_bit(pullup_control_reg_ff[gi]),
            .pin_in(pin_in[gi]),
            .pin_out(pin_out[gi]),
            .pin_oe(pin_oe[gi]),
            .pullup_en(pullup_en[gi]),
            .gpio_in(gpio_in[gi]),
            .periph_in(periph_in[gi])
         );
      end
   endgenerate
endmodule : pps_port1
`default_nettype wire

// ===== tb/pps_port1_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pps_port1_properties (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic avs_waitrequest, // Wait
   input wire logic [7:0] pin_in, // Pins
   input wire logic [7:0] pin_oe, // Enables
   input wire logic [7:0] pullup_en, // Pull-ups
   input wire logic ext_int3_in, // Int 3
   input wire logic ext_int2_in, // Int 2
   input wire logic ext_int1_in, // Int 1
   input wire logic timer_f_event_input, // Event F
   input wire logic timer_c_event_input, // Event C
   input wire logic timer_b_event_input // Event B
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence req_start; $rose(avs_read || avs_write); endsequence
   sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   one_wait_a: assert property (req_start |-> one_wait)
      else $error("wait state count wrong");
   idle_ready_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait while idle");
   reset_clear_a: assert property ($rose(nrst) |-> pullup_en == 8'h00 && pin_oe == 8'h00)
      else $error("outputs active after reset");
   pull_undriven_a: assert property ((pullup_en & pin_oe) == 8'h00)
      else $error("pull-up on a driven pin");
   int3_pin_a: assert property (!ext_int3_in |-> !pin_in[7])
      else $error("int 3 low without pin 7 low");
   int2_pin_a: assert property (!ext_int2_in |-> !pin_in[6])
      else $error("int 2 low without pin 6 low");
   int1_pin_a: assert property (!ext_int1_in |-> !pin_in[5])
      else $error("int 1 low without pin 5 low");
   event_pair_a: assert property ({ext_int3_in, ext_int2_in, ext_int1_in} ==
      {timer_f_event_input, timer_c_event_input, timer_b_event_input})
      else $error("event differs from interrupt");
endmodule : pps_port1_properties
bind pps_port1 pps_port1_properties i_pps_port1_properties (.clk, .nrst, .avs_read,
   .avs_write, .avs_waitrequest, .pin_in, .pin_oe, .pullup_en, .ext_int3_in, .ext_int2_in,
   .ext_int1_in, .timer_f_event_input, .timer_c_event_input, .timer_b_event_input);
`default_nettype wire

// ===== tb/tb_pps_port1.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pps_port1;
   import pps_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, pwm_out = 1'b0;
   logic timer_f_high_compare_out = 1'b0, timer_f_low_compare_out = 1'b0, clock_out = 1'b0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
   logic [7:0] pin_in = 8'h00, pin_out, pin_oe, pullup_en;
   logic [31:0] q;
   logic avs_waitrequest, ext_int3_in, ext_int2_in, ext_int1_in;
   logic timer_f_event_input, timer_c_event_input, timer_b_event_input;
   int fails = 0, compares = 0;
   always #4 clk = ~clk;
   pps_port1 #(.REDUCED(1'b0))
      i_pps_port1 (.clk, .nrst, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out,
      .pin_oe, .pullup_en, .pwm_out, .timer_f_high_compare_out, .timer_f_low_compare_out,
      .clock_out, .ext_int3_in, .ext_int2_in, .ext_int1_in, .timer_f_event_input,
      .timer_c_event_input, .timer_b_event_input);
   task automatic give_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Request stands until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         give_verdict;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic t_reset;
      rd(PPS_OFS_PULLUP, 8'h00);
      rd(PPS_OFS_FUNC, 8'h00);
      chk(pullup_en, 8'h00);
      bus(1'b1, 4'h2, 8'hFF);
      rd(4'h2, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_pullup;
      bus(1'b1, PPS_OFS_DIR, 8'h0F);
      bus(1'b1, PPS_OFS_PULLUP, 8'hFF);
      rd(PPS_OFS_PULLUP, 8'hFF);
      chk(pullup_en, 8'hF0);
      bus(1'b1, PPS_OFS_PULLUP, 8'h00);
      chk(pullup_en, 8'h00);
      bus(1'b1, PPS_OFS_PULLUP, 8'hFF);
      $display("pull-up test done");
   endtask : t_pullup
   task automatic t_func;
      bus(1'b1, PPS_OFS_DIR, 8'hFF);
      bus(1'b1, PPS_OFS_FUNC, 8'hF7);
      rd(PPS_OFS_FUNC, 8'hF7);
      chk(pullup_en, 8'hE0);
      chk(pin_oe, 8'h1F);
      for (int i = 0; i < 2; i++) begin
         pwm_out <= i[0];
         timer_f_high_compare_out <= !i[0];
         timer_f_low_compare_out <= i[0];
         clock_out <= !i[0];
         @(posedge clk);
         chk(pin_out[4:0], {i[0], 1'b0, !i[0], i[0], !i[0]});
      end
      pin_in <= 8'hA0;
      @(posedge clk);
      chk({ext_int3_in, ext_int2_in, ext_int1_in}, 3'b101);
      pin_in <= 8'h40;
      @(posedge clk);
      chk({timer_f_event_input, timer_c_event_input, timer_b_event_input}, 3'b010);
      $display("function test done");
   endtask : t_func
   task automatic t_gpio;
      bus(1'b1, PPS_OFS_FUNC, 8'h00);
      bus(1'b1, PPS_OFS_DATA, 8'h5A);
      chk(pin_oe, 8'hFF);
      chk(pin_out, 8'h5A);
      chk(pullup_en, 8'h00);
      chk({ext_int3_in, ext_int2_in, ext_int1_in}, 3'b111);
      bus(1'b1, PPS_OFS_DIR, 8'h0F);
      rd(PPS_OFS_DATA, 8'h4A);
      $display("general I/O test done");
   endtask : t_gpio
   task automatic t_mid_reset;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(pullup_en, 8'h00);
      chk(pin_oe, 8'h00);
      nrst <= 1'b1;
      @(posedge clk);
      rd(PPS_OFS_PULLUP, 8'h00);
      rd(PPS_OFS_FUNC, 8'h00);
      $display("mid-run reset test done");
   endtask : t_mid_reset
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset;
      t_pullup;
      t_func;
      t_gpio;
      t_mid_reset;
      give_verdict;
   end
endmodule : tb_pps_port1
`default_nettype wire
